//--- rtl/tcg_pkg.sv
package tcg_pkg;
	// timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CARRIER_HZ = 1_000;
	localparam int unsigned CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
	localparam int unsigned CYCLES_PER_SYMBOL = 10;
	localparam int unsigned SYMBOLS_PER_FRAME = 100;
	// marks per symbol
	localparam logic [3:0] MARKS_ZERO = 4'h2;
	localparam logic [3:0] MARKS_ONE = 4'h5;
	localparam logic [3:0] MARKS_POS = 4'h8;
	// control segment positions
	localparam int unsigned POS_MARK5 = 49;
	localparam int unsigned POS_YEAR_LO = 50;
	localparam int unsigned POS_EMPTY = 54;
	localparam int unsigned POS_YEAR_HI = 55;
	localparam int unsigned POS_MARK6 = 59;
	localparam int unsigned POS_LEAP_PEND = 60;
	localparam int unsigned POS_LEAP_DIR = 61;
	localparam int unsigned POS_DST_PEND = 62;
	localparam int unsigned POS_DST_ACT = 63;
	localparam int unsigned POS_TZ_SIGN = 64;
	localparam int unsigned POS_TZ_HOURS = 65;
	localparam int unsigned POS_MARK7 = 69;
	localparam int unsigned POS_TZ_HALF = 70;
	localparam int unsigned POS_QUALITY = 71;
	localparam int unsigned POS_PARITY = 75;
	// quality values
	localparam logic [3:0] QUALITY_LOCKED = 4'h0;
	localparam logic [3:0] QUALITY_FAILED = 4'hf;
	// code selection
	localparam logic [3:0] CODE_B002 = 4'h0;
	localparam logic [3:0] CODE_B003 = 4'h1;
	localparam logic [3:0] CODE_B006 = 4'h2;
	localparam logic [3:0] CODE_B007 = 4'h3;
	localparam logic [3:0] CODE_AFNOR = 4'h4;
	localparam logic [3:0] CODE_IEEE1344 = 4'h5;
	localparam logic [3:0] CODE_C37118 = 4'h6;
	typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_POS} symbol_t;
endpackage : tcg_pkg

//--- rtl/tcg_symbol_buffer.sv
`timescale 1ns/1ps
module tcg_symbol_buffer #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] slot;
		logic rd;
		logic wr;
		logic [1:0] count;
	} buf_state_t;
	buf_state_t state;
	buf_state_t next_state;
	logic push;
	logic pop;

	if (WIDTH < 1) begin : g_width
		$error("buffer width must be at least one");
	end

	assign in_ready = (state.count != 2'h2);
	assign out_valid = (state.count != 2'h0);
	assign out_data = state.slot[state.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_state = state;
		if (push) begin
			next_state.slot[state.wr] = in_data;
			next_state.wr = ~state.wr;
		end
		if (pop) begin
			next_state.rd = ~state.rd;
		end
		case ({push, pop})
			2'b10: next_state.count = state.count + 2'h1;
			2'b01: next_state.count = state.count - 2'h1;
			default: next_state.count = state.count;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= '0;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	a_buf_never_over: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state.count <= 2'h2)
		else $error("symbol buffer count above two");
endmodule : tcg_symbol_buffer

//--- rtl/tcg_modulator.sv
`timescale 1ns/1ps
module tcg_modulator (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// symbol in
	input wire logic sym_valid,
	output logic sym_ready,
	input wire logic [1:0] sym_kind,
	// symbol boundary
	output logic sym_start,
	// outputs
	output logic level_shift_output,
	output logic carrier_phase,
	output logic carrier_mark
);
	localparam int unsigned CC = tcg_pkg::CARRIER_CYCLES;
	typedef struct packed {
		logic [16:0] tick;
		logic [3:0] wave;
		logic [3:0] marks;
		logic busy;
		logic shift;
		logic phase;
		logic mark;
	} mod_state_t;
	mod_state_t state;
	mod_state_t next_state;
	logic wave_end;
	logic sym_end;

	function automatic logic [3:0] marks_of(input logic [1:0] k);
		case (k)
			tcg_pkg::SYM_ONE: marks_of = tcg_pkg::MARKS_ONE; // [RULE20]
			tcg_pkg::SYM_POS: marks_of = tcg_pkg::MARKS_POS; // [RULE21]
			default: marks_of = tcg_pkg::MARKS_ZERO; // [RULE19]
		endcase
	endfunction : marks_of

	assign wave_end = (state.tick == 17'(CC - 1));
	assign sym_end = wave_end &&
		(state.wave == 4'(tcg_pkg::CYCLES_PER_SYMBOL - 1));
	// a new symbol is taken only at a symbol boundary or when idle
	assign sym_ready = !state.busy || sym_end;
	assign sym_start = sym_valid && sym_ready;
	assign level_shift_output = state.shift;
	assign carrier_phase = state.phase;
	assign carrier_mark = state.mark;

	always_comb begin
		next_state = state;
		if (state.busy) begin
			next_state.tick = wave_end ? 17'h0 : state.tick + 17'h1;
			if (wave_end) begin
				next_state.wave = state.wave + 4'h1;
			end
		end
		if (sym_start) begin
			next_state.busy = 1'b1;
			next_state.tick = 17'h0;
			next_state.wave = 4'h0;
			next_state.marks = marks_of(sym_kind);
		end else if (sym_end) begin
			next_state.busy = 1'b0;
		end
		// both outputs come from one counter, so they never drift apart
		if (next_state.busy) begin // [RULE14]
			next_state.mark = (next_state.wave < next_state.marks); // [RULE18]
			next_state.shift = next_state.mark; // [RULE22]
			next_state.phase = (next_state.tick < 17'(CC / 2));
		end else begin
			next_state.mark = 1'b0;
			next_state.shift = 1'b0;
			next_state.phase = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= '0;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	a_mod_shift_mark: assert property ( // [RULE14]
		@(posedge ref_clk) disable iff (sys_rst)
		state.shift == state.mark)
		else $error("level shift and carrier mark disagree");
	a_mod_zero_marks: assert property ( // [RULE19]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && sym_start && sym_kind == tcg_pkg::SYM_ZERO ##1 clk_en
		|-> state.marks == tcg_pkg::MARKS_ZERO)
		else $error("zero symbol not two marks");
	a_mod_one_marks: assert property ( // [RULE20]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && sym_start && sym_kind == tcg_pkg::SYM_ONE
		|=> state.marks == tcg_pkg::MARKS_ONE)
		else $error("one symbol not five marks");
	a_mod_pos_marks: assert property ( // [RULE21]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && sym_start && sym_kind == tcg_pkg::SYM_POS
		|=> state.marks == tcg_pkg::MARKS_POS)
		else $error("position symbol not eight marks");
	a_mod_mark_count: assert property ( // [RULE18]
		@(posedge ref_clk) disable iff (sys_rst)
		state.busy |-> state.mark == (state.wave < state.marks))
		else $error("carrier mark not tied to wave count");
endmodule : tcg_modulator

//--- rtl/serial_time_code_generator.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: ieee1344: marker five at 49, year units bcd at 50..53.
// RULE2: bit 54 always zero; year tens bcd at 55..58.
// RULE3: marker six at 59; leap pending at 60 up to 59 s ahead.
// RULE4: leap direction bit 61 always signals insertion (zero).
// RULE5: dst pending flag at bit 62 before a changeover.
// RULE6: dst active flag at bit 63 while daylight saving holds.
// RULE7: time zone sign at bit 64, zero plus, one minus.
// RULE8: whole-hour offset binary at 65..68; time plus offset is utc.
// RULE9: marker seven at 69; half-hour offset flag at 70.
// RULE10: quality field at 71..74; zero locked, 0xf failed.
// RULE11: parity at 75 over all preceding bits of the frame.
// RULE12: quality 1111 until first sync after reset, then 0000.
// RULE13: test option forces the quality field to all zeros.
// RULE14: level shift and carrier outputs always produced together.
// RULE15: eight irig-b variants at 100 pps, optional binary seconds, year; only b002, b003, b006 and b007 are built.
// RULE16: afnor sends bcd time, complete date and binary seconds.
// RULE17: c37.118 is ieee1344 with the offset sign inverted.
// RULE18: 1 khz carrier, symbol coded by marks among ten cycles.
// RULE19: zero is two marks then eight spaces.
// RULE20: one is five marks then five spaces.
// RULE21: position identifier is eight marks then two spaces.
// RULE22: level shift high 2, 5 or 8 ms of each 10 ms symbol.
// RULE23: frame starts on second boundary with reference marker.
module serial_time_code_generator #(
	parameter bit PARITY_ODD = 1'b0
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// configuration
	input wire logic [3:0] code_select,
	input wire logic quality_disable,
	// time base, valid when second_tick pulses
	input wire logic second_tick,
	input wire logic time_synced,
	input wire logic [6:0] bcd_seconds,
	input wire logic [6:0] bcd_minutes,
	input wire logic [5:0] bcd_hours,
	input wire logic [9:0] bcd_day_of_year,
	input wire logic [5:0] bcd_day_of_month,
	input wire logic [4:0] bcd_month,
	input wire logic [7:0] bcd_year,
	input wire logic [16:0] binary_seconds,
	// control function inputs
	input wire logic leap_pending,
	input wire logic dst_pending,
	input wire logic dst_active,
	input wire logic tz_negative,
	input wire logic [3:0] tz_hours,
	input wire logic tz_half_hour,
	// outputs
	output logic level_shift_output,
	output logic carrier_phase,
	output logic carrier_mark,
	output logic frame_active,
	output logic [6:0] symbol_index,
	output logic ever_synced
);
	typedef struct packed {
		logic [99:0] frame;
		logic [6:0] index;
		logic sending;
		logic synced;
		logic [6:0] out_index;
		logic fresh;
	} gen_state_t;
	gen_state_t state;
	gen_state_t next_state;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [1:0] buf_out_data;
	logic [1:0] sym_kind;
	logic sym_push;
	logic sym_start;
	logic [99:0] built;
	logic [3:0] quality;
	logic is_ieee;
	logic is_position;

	if (tcg_pkg::SYMBOLS_PER_FRAME != 100) begin : g_frame_len
		$error("frame length must be 100 symbols");
	end

	// reference marker at 0 and markers at 9 and every ten symbols after
	function automatic logic pos_slot(input logic [6:0] i);
		pos_slot = (i == 7'h00) || ((i % 7'd10) == 7'd9);
	endfunction : pos_slot

	assign is_ieee = (code_select == tcg_pkg::CODE_IEEE1344) ||
		(code_select == tcg_pkg::CODE_C37118);
	// quality follows first sync, test option blanks it
	assign quality = quality_disable ? 4'h0 : // [RULE13]
		(state.synced ? tcg_pkg::QUALITY_LOCKED :
		tcg_pkg::QUALITY_FAILED); // [RULE12] [RULE10]

	always_comb begin
		logic [99:0] f;
		logic par;
		f = '0;
		par = 1'b0;
		// time of year, bcd, with unit spacers at fixed zero positions
		f[4:1] = bcd_seconds[3:0];
		f[8:6] = bcd_seconds[6:4];
		f[13:10] = bcd_minutes[3:0];
		f[17:15] = bcd_minutes[6:4];
		f[23:20] = bcd_hours[3:0];
		f[26:25] = bcd_hours[5:4];
		f[33:30] = bcd_day_of_year[3:0];
		f[38:35] = bcd_day_of_year[7:4];
		f[41:40] = bcd_day_of_year[9:8];
		case (code_select)
			tcg_pkg::CODE_B006, tcg_pkg::CODE_B007: begin // [RULE15]
				f[53:50] = bcd_year[3:0];
				f[58:55] = bcd_year[7:4];
			end
			tcg_pkg::CODE_AFNOR: begin // [RULE16]
				f[48:43] = bcd_day_of_month;
				f[54:50] = bcd_month;
				f[58:55] = bcd_year[3:0];
				f[63:60] = bcd_year[7:4];
			end
			tcg_pkg::CODE_IEEE1344, tcg_pkg::CODE_C37118: begin
				f[tcg_pkg::POS_YEAR_LO +: 4] = bcd_year[3:0]; // [RULE1]
				f[tcg_pkg::POS_EMPTY] = 1'b0; // [RULE2]
				f[tcg_pkg::POS_YEAR_HI +: 4] = bcd_year[7:4]; // [RULE2]
				f[tcg_pkg::POS_LEAP_PEND] = leap_pending; // [RULE3]
				f[tcg_pkg::POS_LEAP_DIR] = 1'b0; // [RULE4]
				f[tcg_pkg::POS_DST_PEND] = dst_pending; // [RULE5]
				f[tcg_pkg::POS_DST_ACT] = dst_active; // [RULE6]
				// c37.118 turns the sign round
				f[tcg_pkg::POS_TZ_SIGN] = tz_negative ^
					(code_select == tcg_pkg::CODE_C37118); // [RULE7] [RULE17]
				f[tcg_pkg::POS_TZ_HOURS +: 4] = tz_hours; // [RULE8]
				f[tcg_pkg::POS_TZ_HALF] = tz_half_hour; // [RULE9]
				f[tcg_pkg::POS_QUALITY +: 4] = quality; // [RULE10]
			end
			default: begin
			end
		endcase
		// markers five, six, seven land here and carry no data bit
		for (int i = 0; i < 100; i++) begin
			if (pos_slot(7'(i))) begin
				f[i] = 1'b0; // [RULE1] [RULE3] [RULE9]
			end
		end
		if (is_ieee) begin
			for (int i = 0; i < tcg_pkg::POS_PARITY; i++) begin
				par = par ^ f[i];
			end
			f[tcg_pkg::POS_PARITY] = par ^ PARITY_ODD; // [RULE11]
		end
		// straight binary seconds in the last field
		if (code_select == tcg_pkg::CODE_B003 ||
			code_select == tcg_pkg::CODE_B007 ||
			is_ieee || code_select == tcg_pkg::CODE_AFNOR) begin
			f[88:80] = binary_seconds[8:0]; // [RULE15] [RULE16]
			f[97:90] = binary_seconds[16:9];
		end
		built = f;
	end

	assign is_position = pos_slot(state.index);
	assign sym_kind = is_position ? tcg_pkg::SYM_POS :
		(state.frame[state.index] ? tcg_pkg::SYM_ONE : tcg_pkg::SYM_ZERO);
	assign sym_push = state.sending;

	always_comb begin
		next_state = state;
		if (time_synced) begin
			next_state.synced = 1'b1; // [RULE12]
		end
		if (sym_push && buf_in_ready) begin
			if (state.index == 7'(tcg_pkg::SYMBOLS_PER_FRAME - 1)) begin
				next_state.sending = 1'b0;
			end else begin
				next_state.index = state.index + 7'h1;
			end
		end
		if (sym_start) begin
			// the first start after a tick is symbol 0 of the new frame
			next_state.out_index = state.fresh ? 7'h0 :
				state.out_index + 7'h1;
			next_state.fresh = 1'b0;
		end
		// latch the whole frame at the boundary, starting with the marker
		if (second_tick) begin // [RULE23]
			next_state.frame = built;
			next_state.index = 7'h0;
			next_state.out_index = 7'h0;
			next_state.fresh = 1'b1;
			next_state.sending = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= '0;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// buffer lets a frame boundary restart without dropping the marker
	tcg_symbol_buffer #(
		.WIDTH(2)
	) u_buffer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst || (clk_en && second_tick)),
		.clk_en(clk_en),
		.in_valid(sym_push),
		.in_ready(buf_in_ready),
		.in_data(sym_kind),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	tcg_modulator u_modulator (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sym_valid(buf_out_valid),
		.sym_ready(buf_out_ready),
		.sym_kind(buf_out_data),
		.sym_start(sym_start),
		.level_shift_output(level_shift_output),
		.carrier_phase(carrier_phase),
		.carrier_mark(carrier_mark)
	);

	assign frame_active = state.sending;
	assign symbol_index = state.out_index;
	assign ever_synced = state.synced;

	a_quality_failed: assert property ( // [RULE12]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee && !quality_disable && !state.synced
		|-> built[74:71] == 4'hf)
		else $error("quality not failed before sync");
	a_quality_locked: assert property ( // [RULE10] [RULE12]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee && !quality_disable && state.synced
		|-> built[74:71] == tcg_pkg::QUALITY_LOCKED)
		else $error("quality not locked after sync");
	a_sync_sticky: assert property ( // [RULE12]
		@(posedge ref_clk) disable iff (sys_rst)
		state.synced |=> state.synced)
		else $error("sync flag cleared without reset");
	a_quality_test: assert property ( // [RULE13]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee && quality_disable |-> built[74:71] == 4'h0)
		else $error("quality not blanked in test mode");
	a_leap_insert: assert property ( // [RULE4]
		@(posedge ref_clk) disable iff (sys_rst)
		built[61] == 1'b0)
		else $error("leap deletion signalled");
	a_empty_bit: assert property ( // [RULE2]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> !built[54])
		else $error("bit 54 not zero");
	a_parity_ok: assert property ( // [RULE11]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> (^built[75:0]) == PARITY_ODD)
		else $error("frame parity wrong");
	a_c37_sign: assert property ( // [RULE17]
		@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_C37118 |-> built[64] == !tz_negative)
		else $error("c37 sign not inverted");
	a_frame_start: assert property ( // [RULE23]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && second_tick |=> state.index == 7'h0 && state.sending)
		else $error("frame not restarted at second");
	a_index_restart: assert property ( // [RULE23]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && sym_start && state.fresh && !second_tick
		|-> buf_out_data == tcg_pkg::SYM_POS)
		else $error("frame not opened by reference marker");
	a_ref_marker: assert property ( // [RULE23]
		@(posedge ref_clk) disable iff (sys_rst)
		state.index == 7'h00 |-> sym_kind == tcg_pkg::SYM_POS)
		else $error("symbol 0 not a marker");
	a_marker_slots: assert property ( // [RULE1] [RULE3] [RULE9]
		@(posedge ref_clk) disable iff (sys_rst)
		state.index == 7'(tcg_pkg::POS_MARK5) ||
		state.index == 7'(tcg_pkg::POS_MARK6) ||
		state.index == 7'(tcg_pkg::POS_MARK7)
		|-> sym_kind == tcg_pkg::SYM_POS)
		else $error("control marker missing");
	a_seconds_units: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && second_tick
		|=> state.frame[4:1] == $past(bcd_seconds[3:0]))
		else $error("seconds units not latched");
	a_year_units: assert property ( // [RULE1]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> built[53:50] == bcd_year[3:0])
		else $error("year units misplaced");
	a_year_tens: assert property ( // [RULE2]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> built[58:55] == bcd_year[7:4])
		else $error("year tens misplaced");
	a_tz_hours: assert property ( // [RULE8] [RULE9]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> built[68:65] == tz_hours && built[70] == tz_half_hour)
		else $error("time zone offset misplaced");
	a_dst_flags: assert property ( // [RULE3] [RULE5] [RULE6]
		@(posedge ref_clk) disable iff (sys_rst)
		is_ieee |-> built[63:60] == {dst_active, dst_pending, 1'b0,
		leap_pending})
		else $error("pending flags misplaced");
	a_sign_ieee: assert property ( // [RULE7]
		@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_IEEE1344 |-> built[64] == tz_negative)
		else $error("sign wrong in ieee1344");
	a_plain_b002: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_B002 |-> built[99:42] == '0)
		else $error("b002 carries extra fields");
	a_sbs_field: assert property ( // [RULE15]
		@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_B003
		|-> {built[97:90], built[88:80]} == binary_seconds)
		else $error("binary seconds misplaced");
	a_afnor_date: assert property ( // [RULE16]
		@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_AFNOR
		|-> built[48:43] == bcd_day_of_month && built[54:50] == bcd_month
		&& {built[97:90], built[88:80]} == binary_seconds)
		else $error("afnor date or seconds misplaced");

	c_frame_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(state.sending));
	c_sync_seen: cover property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(state.synced));
	c_stall: cover property (@(posedge ref_clk) disable iff (sys_rst)
		sym_push && !buf_in_ready);
	c_c37: cover property (@(posedge ref_clk) disable iff (sys_rst)
		code_select == tcg_pkg::CODE_C37118 && second_tick);
	c_mid_restart: cover property (@(posedge ref_clk) disable iff (sys_rst)
		second_tick && state.sending && state.index != 7'h0);
endmodule : serial_time_code_generator

//--- bench/tcg_receiver_model.sv
`timescale 1ns/1ps
module tcg_receiver_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// line from the generator
	input wire logic level_shift_output,
	input wire logic carrier_mark,
	input wire logic carrier_phase,
	// what the receiver measured
	output logic pair_broken,
	output logic [31:0] phase_high_len,
	output logic [31:0] level_run
);
	logic [31:0] phase_run;
	logic last_phase;
	// listen only: the receiver never drives anything back
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pair_broken <= 1'b0;
			phase_high_len <= '0;
			level_run <= '0;
			phase_run <= '0;
			last_phase <= 1'b0;
		end else begin
			if (level_shift_output !== carrier_mark) begin
				pair_broken <= 1'b1;
			end
			phase_run <= carrier_phase ? phase_run + 32'h1 : '0;
			last_phase <= carrier_phase;
			if (last_phase && !carrier_phase) begin
				phase_high_len <= phase_run;
			end
			level_run <= level_shift_output ? level_run + 32'h1 : '0;
		end
	end
endmodule : tcg_receiver_model

//--- bench/serial_time_code_generator_tb.sv
`timescale 1ns/1ps
module serial_time_code_generator_tb;
	logic ref_clk, sys_rst, clk_en, quality_disable, second_tick, time_synced;
	logic [3:0] code_select, tz_hours;
	logic [6:0] bcd_seconds, bcd_minutes, symbol_index;
	logic [5:0] bcd_hours, bcd_day_of_month;
	logic [9:0] bcd_day_of_year;
	logic [4:0] bcd_month;
	logic [7:0] bcd_year;
	logic [16:0] binary_seconds;
	logic leap_pending, dst_pending, dst_active, tz_negative, tz_half_hour;
	logic level_shift_output, carrier_phase, carrier_mark;
	logic frame_active, ever_synced, pair_broken;
	logic [31:0] phase_high_len, level_run;
	logic [6:0] held_index;
	logic held_level;
	int failures;
	int checks_done;
	int waited;

	serial_time_code_generator DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .code_select(code_select),
		.quality_disable(quality_disable), .second_tick(second_tick),
		.time_synced(time_synced), .bcd_seconds(bcd_seconds),
		.bcd_minutes(bcd_minutes), .bcd_hours(bcd_hours),
		.bcd_day_of_year(bcd_day_of_year),
		.bcd_day_of_month(bcd_day_of_month), .bcd_month(bcd_month),
		.bcd_year(bcd_year), .binary_seconds(binary_seconds),
		.leap_pending(leap_pending), .dst_pending(dst_pending),
		.dst_active(dst_active), .tz_negative(tz_negative),
		.tz_hours(tz_hours), .tz_half_hour(tz_half_hour),
		.level_shift_output(level_shift_output),
		.carrier_phase(carrier_phase), .carrier_mark(carrier_mark),
		.frame_active(frame_active), .symbol_index(symbol_index),
		.ever_synced(ever_synced));

	tcg_receiver_model receiver (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.level_shift_output(level_shift_output),
		.carrier_mark(carrier_mark), .carrier_phase(carrier_phase),
		.pair_broken(pair_broken), .phase_high_len(phase_high_len),
		.level_run(level_run));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		checks_done++;
		if (seen !== expected) begin
			failures++;
			$display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, expected);
		end
	endtask : check

	// land one nanosecond past the edge so every update has settled
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic pulse_reset();
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		step(2);
		check(level_shift_output | carrier_phase | frame_active, 1'b0);
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		step(1);
	endtask : pulse_reset

	// a tick launches a frame; the first marker must show within a few cycles
	task automatic tick_and_wait();
		@(posedge ref_clk);
		second_tick <= 1'b1;
		@(posedge ref_clk);
		second_tick <= 1'b0;
		#1;
		waited = 1;
		while (level_shift_output !== 1'b1 && waited < 6) begin
			step(1);
			waited++;
		end
		check(waited <= 4, 1'b1);
	endtask : tick_and_wait

	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		code_select = tcg_pkg::CODE_B002;
		quality_disable = 1'b0;
		second_tick = 1'b0;
		time_synced = 1'b0;
		bcd_seconds = 7'h00;
		bcd_minutes = 7'h00;
		bcd_hours = 6'h00;
		bcd_day_of_year = 10'h001;
		bcd_day_of_month = 6'h01;
		bcd_month = 5'h01;
		bcd_year = 8'h00;
		binary_seconds = 17'h00000;
		leap_pending = 1'b0;
		dst_pending = 1'b0;
		dst_active = 1'b0;
		tz_negative = 1'b0;
		tz_hours = 4'h0;
		tz_half_hour = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		step(1);
		check(level_shift_output | carrier_mark | ever_synced, 1'b0);
		// every code starts its frame with a marker on both outputs
		for (int c = 0; c <= 6; c++) begin
			@(posedge ref_clk);
			code_select <= c[3:0];
			quality_disable <= c[0];
			bcd_seconds <= 7'h59 - 7'(c);
			bcd_minutes <= 7'h30 + 7'(c);
			bcd_hours <= 6'h23;
			bcd_year <= 8'h14 + 8'(c);
			binary_seconds <= 17'h15180 - 17'(c);
			leap_pending <= c[0];
			dst_pending <= c[1];
			dst_active <= c[2];
			tz_negative <= c[0];
			tz_hours <= 4'(c);
			tz_half_hour <= c[1];
			pulse_reset();
			tick_and_wait();
			check(symbol_index, 7'h00);
			check(frame_active, 1'b1);
			check(carrier_mark, 1'b1);
			check(carrier_phase, 1'b1);
		end
		// sticky sync flag behind the quality field
		@(posedge ref_clk);
		code_select <= tcg_pkg::CODE_IEEE1344;
		quality_disable <= 1'b0;
		pulse_reset();
		tick_and_wait();
		check(ever_synced, 1'b0);
		@(posedge ref_clk);
		time_synced <= 1'b1;
		@(posedge ref_clk);
		time_synced <= 1'b0;
		step(2);
		check(ever_synced, 1'b1);
		step(20);
		check(ever_synced, 1'b1);
		// first carrier wave of the opening marker: half high, marks go on
		waited = 0;
		while (carrier_phase === 1'b1 && waited < 60000) begin
			step(1);
			waited++;
		end
		step(1);
		check(phase_high_len, tcg_pkg::CARRIER_CYCLES / 2);
		check(level_shift_output, 1'b1);
		check(level_run > tcg_pkg::CARRIER_CYCLES / 2, 1'b1);
		check(pair_broken, 1'b0);
		// a tick in mid-frame restarts the count at the marker
		tick_and_wait();
		step(5);
		check(symbol_index, 7'h00);
		check(level_shift_output, 1'b1);
		// clock enable low freezes the outputs where they stand
		@(posedge ref_clk);
		clk_en <= 1'b0;
		step(1);
		held_index = symbol_index;
		held_level = level_shift_output;
		step(50);
		check(symbol_index, held_index);
		check(level_shift_output, held_level);
		check(carrier_mark, held_level);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		step(5);
		check(pair_broken, 1'b0);
		report_and_stop();
	end

	// the run needs just over 50000 cycles; past 90000 it has hung
	initial begin
		#(90_000 * 10);
		failures++;
		report_and_stop();
	end
endmodule : serial_time_code_generator_tb
